//--- msc_pkg.sv
package msc_pkg;
   // Register port geometry
   localparam int MSC_ADDR_W = 7;
   localparam int MSC_DATA_W = 16;
   localparam logic [6:0] MSC_SYSCTL_ADDR = 7'h00;
   localparam logic [15:0] MSC_SYSCTL_RST = 16'h0003;
   localparam logic [15:0] MSC_RDATA_IDLE = 16'h0000;
   // Field layout of system_control
   localparam int MSC_CTRL_W = 7;
   localparam int MSC_RSVD_HI_BIT = 15;
   localparam int MSC_RSVD_LO_BIT = 7;
   localparam int MSC_BAUD_LSB = 8;
   localparam int MSC_BAUD_W = 7;
   localparam int MSC_IB_EN_BIT = 6;
   localparam int MSC_IB_GAIN_LSB = 4;
   localparam int MSC_U_GAIN_LSB = 2;
   localparam int MSC_IA_GAIN_LSB = 0;
   // Baud-rate codes per strap setting
   localparam logic [6:0] MSC_BAUD_2400 = 7'h2e;
   localparam logic [6:0] MSC_BAUD_4800 = 7'h16;
   localparam logic [6:0] MSC_BAUD_9600 = 7'h0b;
   localparam logic [6:0] MSC_BAUD_19200 = 7'h05;
   localparam logic [6:0] MSC_BAUD_NONE = 7'h00;
   // Gain factors
   localparam logic [4:0] MSC_GAIN_1 = 5'h01;
   localparam logic [4:0] MSC_GAIN_2 = 5'h02;
   localparam logic [4:0] MSC_GAIN_4 = 5'h04;
   localparam logic [4:0] MSC_GAIN_8 = 5'h08;
   localparam logic [4:0] MSC_GAIN_16 = 5'h10;
   // Converter sample width
   localparam int MSC_ADC_W = 24;

   typedef struct packed {
      logic ib_run;
      logic [4:0] ib_gain;
      logic [4:0] u_gain;
      logic [4:0] ia_gain;
   } msc_afe_cfg_t;

   // Gain map shared by voltage and current B
   function automatic logic [4:0] msc_gain_low(input logic [1:0] sel);
      unique case (sel)
         2'h0: msc_gain_low = MSC_GAIN_1;
         2'h1: msc_gain_low = MSC_GAIN_2;
         default: msc_gain_low = MSC_GAIN_4;
      endcase
   endfunction

   function automatic logic [4:0] msc_gain_ia(input logic [1:0] sel);
      unique case (sel)
         2'h0: msc_gain_ia = MSC_GAIN_1;
         2'h1: msc_gain_ia = MSC_GAIN_2;
         2'h2: msc_gain_ia = MSC_GAIN_8;
         default: msc_gain_ia = MSC_GAIN_16;
      endcase
   endfunction

   // Full readable word from control bits and baud code
   function automatic logic [15:0] msc_word(input logic [6:0] ctrl, input logic [6:0] baud);
      logic [15:0] w;
      w = 16'h0000;
      w[MSC_BAUD_LSB +: MSC_BAUD_W] = baud;
      w[MSC_CTRL_W-1:0] = ctrl;
      w[MSC_RSVD_HI_BIT] = 1'b0;
      w[MSC_RSVD_LO_BIT] = 1'b0;
      msc_word = w;
   endfunction
endpackage

//--- msc_baud_strap.sv
`timescale 1ns/100ps
`default_nettype none
module msc_baud_strap import msc_pkg::*; #(
   parameter bit FIXED_4800 = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_baud_strap_high,
   input wire logic i_baud_strap_low,
   input wire logic i_uart_select,
   output logic [6:0] o_baud_code
);
   logic [2:0] sync1_q, sync2_q;
   logic [6:0] code_d, code_q;

   always_comb begin
      unique case (sync2_q[1:0])
         2'h0: code_d = MSC_BAUD_2400;
         2'h1: code_d = MSC_BAUD_4800;
         2'h2: code_d = MSC_BAUD_9600;
         default: code_d = MSC_BAUD_19200;
      endcase
      if (FIXED_4800) begin
         code_d = MSC_BAUD_4800;
      end
      if (!sync2_q[2]) begin
         code_d = MSC_BAUD_NONE;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         code_q <= MSC_BAUD_NONE;
      end else begin
         sync1_q <= {i_uart_select, i_baud_strap_high, i_baud_strap_low};
         sync2_q <= sync1_q;
         code_q <= code_d;
      end
   end

   assign o_baud_code = code_q;

   AST_SPI_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !sync2_q[2] |=> code_q == MSC_BAUD_NONE)
      else $error("baud code not zero with spi selected");
   AST_STRAP_ENCODE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!FIXED_4800 && sync2_q == 3'h6) |=> code_q == MSC_BAUD_9600)
      else $error("strap 10 did not give 9600 code");
   AST_FIXED_RATE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (FIXED_4800 && sync2_q[2]) |=> code_q == MSC_BAUD_4800)
      else $error("reduced variant not fixed at 4800");
   COV_UART_19200: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      code_q == MSC_BAUD_19200);
endmodule // msc_baud_strap
`default_nettype wire

//--- msc_sysctl.sv
// Overview of operation
// - System control at address zero resets to 0x0003.
// - Bits 14..8 hold read-only baud code from two strap pins.
// - Straps 00,01,10,11 give codes 0x2e,0x16,0x0b,0x05; with FIXED_4800 set, every strap gives 0x16.
// - With SPI selected the baud code reads zero.
// - Baud code is part of the checksum contribution.
// - Bit 6 runs current B converter; off forces its output zero.
// - Bits 5..4 current B gain: 1, 2, 4, 4.
// - Bits 3..2 voltage gain: 1, 2, 4, 4.
// - Bits 1..0 current A gain: 1, 2, 8, 16; reset 16.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module msc_sysctl import msc_pkg::*; #(
   parameter bit FIXED_4800 = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [MSC_ADDR_W-1:0] i_addr,
   input wire logic [MSC_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [MSC_DATA_W-1:0] o_rdata,
   input wire logic i_baud_strap_high,
   input wire logic i_baud_strap_low,
   input wire logic i_uart_select,
   input wire logic [MSC_ADC_W-1:0] i_ib_adc_raw,
   output logic [MSC_ADC_W-1:0] o_ib_adc_data,
   output msc_afe_cfg_t o_afe_cfg,
   output logic [MSC_DATA_W-1:0] o_checksum_word
);
   logic [MSC_CTRL_W-1:0] ctrl_d, ctrl_q;
   logic [MSC_DATA_W-1:0] rdata_d, rdata_q;
   logic [MSC_DATA_W-1:0] csum_d, csum_q;
   logic [MSC_ADC_W-1:0] adc_d, adc_q;
   msc_afe_cfg_t cfg_d, cfg_q;
   logic [6:0] baud_code;
   logic sel_hit;

   msc_baud_strap #(
      .FIXED_4800(FIXED_4800)
   ) u_baud (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_baud_strap_high(i_baud_strap_high),
      .i_baud_strap_low(i_baud_strap_low),
      .i_uart_select(i_uart_select),
      .o_baud_code(baud_code)
   );

   assign sel_hit = (i_addr == MSC_SYSCTL_ADDR);

   // Control bits: only the writable low field is stored
   always_comb begin
      ctrl_d = ctrl_q;
      if (i_wr && sel_hit) begin
         ctrl_d = i_wdata[MSC_CTRL_W-1:0];
      end
   end

   // Read port and checksum contribution
   always_comb begin
      rdata_d = MSC_RDATA_IDLE;
      if (i_rd && sel_hit) begin
         rdata_d = msc_word(ctrl_q, baud_code);
      end
      csum_d = msc_word(ctrl_q, baud_code);
   end

   // Analog front end settings
   always_comb begin
      cfg_d.ib_run = ctrl_q[MSC_IB_EN_BIT];
      cfg_d.ib_gain = msc_gain_low(ctrl_q[MSC_IB_GAIN_LSB +: 2]);
      cfg_d.u_gain = msc_gain_low(ctrl_q[MSC_U_GAIN_LSB +: 2]);
      cfg_d.ia_gain = msc_gain_ia(ctrl_q[MSC_IA_GAIN_LSB +: 2]);
      adc_d = ctrl_q[MSC_IB_EN_BIT] ? i_ib_adc_raw : '0;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ctrl_q <= MSC_SYSCTL_RST[MSC_CTRL_W-1:0];
         rdata_q <= MSC_RDATA_IDLE;
         csum_q <= MSC_SYSCTL_RST;
         adc_q <= '0;
         cfg_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
         csum_q <= csum_d;
         adc_q <= adc_d;
         cfg_q <= cfg_d;
      end
   end

   assign o_rdata = rdata_q;
   assign o_checksum_word = csum_q;
   assign o_ib_adc_data = adc_q;
   assign o_afe_cfg = cfg_q;

   AST_RESET_VALUE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $fell(i_rst) |-> (ctrl_q == 7'h03 ##1 cfg_q.ia_gain == MSC_GAIN_16))
      else $error("control field not at reset value after reset");
   AST_RSVD_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !o_rdata[MSC_RSVD_HI_BIT] && !o_rdata[MSC_RSVD_LO_BIT])
      else $error("reserved bit read as one");
   AST_BAUD_READ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && sel_hit) |=> o_rdata[MSC_BAUD_LSB +: MSC_BAUD_W] == $past(baud_code))
      else $error("baud field does not show strap code");
   AST_CHECKSUM_BAUD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ##1 o_checksum_word[MSC_BAUD_LSB +: MSC_BAUD_W] == $past(baud_code))
      else $error("checksum word lacks baud code");
   AST_IB_OFF: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !ctrl_q[MSC_IB_EN_BIT] |=> (o_ib_adc_data == '0 && !o_afe_cfg.ib_run))
      else $error("current b output not forced to zero");
   AST_IB_GAIN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ctrl_q[5:4] == 2'h3 |=> o_afe_cfg.ib_gain == MSC_GAIN_4)
      else $error("current b gain wrong for code 11");
   AST_U_GAIN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ctrl_q[3:2] == 2'h1 |=> o_afe_cfg.u_gain == MSC_GAIN_2)
      else $error("voltage gain wrong for code 01");
   AST_IA_GAIN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ctrl_q[1:0] == 2'h2 |=> o_afe_cfg.ia_gain == MSC_GAIN_8)
      else $error("current a gain wrong for code 10");
   AST_WRITE_APPLY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_wr && sel_hit) |=> ##1 o_checksum_word == msc_word($past(i_wdata[6:0], 2),
         $past(baud_code)))
      else $error("write not applied or baud bits overwritten");
   AST_UNMAPPED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && !sel_hit) |=> o_rdata == MSC_RDATA_IDLE)
      else $error("unmapped read not zero");

   COV_WRITE: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_wr && sel_hit);
   COV_READ: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_rd && sel_hit);
   COV_IB_ON: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_afe_cfg.ib_run);
   COV_UART_READ: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && sel_hit && baud_code != MSC_BAUD_NONE));
endmodule // msc_sysctl
`default_nettype wire

//--- HANDOVER_unused_guard.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- msc_sysctl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module msc_sysctl_tb import msc_pkg::*; ;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic i_baud_strap_high = 1'b0, i_baud_strap_low = 1'b0, i_uart_select = 1'b0;
   logic [6:0] i_addr = 7'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic [23:0] i_ib_adc_raw = 24'h000000;
   logic [15:0] o_rdata, o_checksum_word, rd2, ck2;
   logic [23:0] o_ib_adc_data, ad2;
   msc_afe_cfg_t o_afe_cfg, cf2;
   logic [31:0] xs = 32'hfe22;
   logic [6:0] ctrl_m = 7'h03;
   int miscompares = 0, num_checks = 0, cycles = 0;
   msc_sysctl #(.FIXED_4800(1'b0)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_baud_strap_high(i_baud_strap_high), .i_baud_strap_low(i_baud_strap_low),
      .i_uart_select(i_uart_select), .i_ib_adc_raw(i_ib_adc_raw), .o_ib_adc_data(o_ib_adc_data),
      .o_afe_cfg(o_afe_cfg), .o_checksum_word(o_checksum_word));
   // Reduced variant beside the full one, same stimulus
   msc_sysctl #(.FIXED_4800(1'b1)) uut2 (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rd2),
      .i_baud_strap_high(i_baud_strap_high), .i_baud_strap_low(i_baud_strap_low),
      .i_uart_select(i_uart_select), .i_ib_adc_raw(i_ib_adc_raw), .o_ib_adc_data(ad2),
      .o_afe_cfg(cf2), .o_checksum_word(ck2));
   initial begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   function automatic logic [31:0] rnd();
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      return xs;
   endfunction
   function automatic logic [4:0] gl(input logic [1:0] s);
      return (s == 2'h0) ? 5'h01 : (s == 2'h1) ? 5'h02 : 5'h04;
   endfunction
   function automatic logic [4:0] ga(input logic [1:0] s);
      return (s == 2'h0) ? 5'h01 : (s == 2'h1) ? 5'h02 : (s == 2'h2) ? 5'h08 : 5'h10;
   endfunction
   function automatic logic [6:0] bm(input logic fx);
      logic [6:0] t[4] = '{7'h2e, 7'h16, 7'h0b, 7'h05};
      if (!i_uart_select) return 7'h00;
      if (fx) return 7'h16;
      return t[{i_baud_strap_high, i_baud_strap_low}];
   endfunction
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic drive(input logic w, input logic r, input logic [6:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr <= w;
      i_rd <= r;
      i_addr <= a;
      i_wdata <= d;
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] q);
      drive(1'b0, 1'b1, a, 16'h0000);
      drive(1'b0, 1'b0, a, 16'h0000);
      #1 q = o_rdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic chk_all();
      logic [15:0] q, w;
      idle(3);
      rd(7'h00, q);
      w = {1'b0, bm(1'b0), 1'b0, ctrl_m};
      chk(q, w);
      chk(o_checksum_word, w);
      chk(ck2, {1'b0, bm(1'b1), 1'b0, ctrl_m});
      w = {ctrl_m[6], gl(ctrl_m[5:4]), gl(ctrl_m[3:2]), ga(ctrl_m[1:0])};
      chk(o_afe_cfg, w);
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      logic [15:0] q;
      logic [23:0] v;
      idle(8);
      i_rst <= 1'b0;
      chk_all();
      for (int s = 0; s < 4; s++) begin
         i_baud_strap_high <= s[1];
         i_baud_strap_low <= s[0];
         i_uart_select <= 1'b1;
         idle(4);
         chk_all();
      end
      i_uart_select <= 1'b0;
      idle(4);
      chk_all();
      i_uart_select <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         // Host keeps reserved bits clear; baud bits get noise
         drive(1'b1, 1'b0, 7'h00, {1'b0, 7'(rnd()), 1'b0, i[2], i[1:0], i[1:0], i[1:0]});
         ctrl_m = {i[2], i[1:0], i[1:0], i[1:0]};
         drive(1'b1, 1'b0, 7'(rnd()) | 7'h01, 16'(rnd()));
         drive(1'b0, 1'b0, 7'h00, 16'h0000);
         chk_all();
         rd(7'h40 | 7'(rnd()), q);
         chk(q, 16'h0000);
         repeat (3) begin
            v = 24'(rnd());
            @(posedge i_ref_clk);
            i_ib_adc_raw <= v;
            @(posedge i_ref_clk);
            #1 chk(o_ib_adc_data, ctrl_m[6] ? v : 24'h000000);
         end
      end
      end_of_test();
   end
endmodule // msc_sysctl_tb
`default_nettype wire
